// *** rtl/external_memory_bus_interface.v ***
// External parallel bus master with wait states, ready and on-chip RAM decode.
`include "ext_bus_defs.vh"
module external_memory_bus_interface (
    input wire clk_sys,
    input wire reset_n,
    input wire req_valid,
    input wire req_write,
    input wire [1:0] req_space,
    input wire [15:0] req_addr,
    input wire [15:0] req_wdata,
    input wire [2:0] wait_states,
    input wire block0_map_select,
    input wire single_access_ram_in_prog,
    input wire single_access_ram_in_data,
    input wire ready_in,
    input wire global_tristate_n,
    input wire [15:0] ext_data_in,
    output reg req_ready,
    output reg resp_valid,
    output reg [15:0] resp_rdata,
    output reg resp_internal,
    output reg [15:0] ext_address_lines,
    output reg ext_address_oe_n,
    output reg [15:0] ext_data_out,
    output reg ext_data_oe_n,
    output reg program_space_select_n,
    output reg data_space_select_n,
    output reg io_space_select_n,
    output reg bus_cycle_strobe_n,
    output reg read_strobe_n,
    output reg write_strobe_n,
    output reg read_write,
    output reg global_select_n,
    output reg control_oe_n
);
    // ==========================================================
    // Sequencer states.
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_DONE = 2'h2;

    // ==========================================================
    // Registers, next values and decode results.
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [3:0] wait_cnt_r;
    reg [3:0] wait_cnt_nxt;
    reg rdy_s1_r;
    reg rdy_s2_r;
    reg off_s1_r;
    reg off_s2_r;
    wire [15:0] din_s2;
    reg internal_hit;
    reg take;
    reg bus_take;
    reg finish;
    genvar gi;

    // ==========================================================
    // Ready and float pins pass two flip-flops before use.
    always @(posedge clk_sys) begin
        rdy_s1_r <= ready_in;
        rdy_s2_r <= rdy_s1_r;
        off_s1_r <= global_tristate_n;
        off_s2_r <= off_s1_r;
    end

    // ==========================================================
    // Data pins pass two flip-flops, one pair per bit.
    // The word is taken only after the read strobe has stood long enough to pass them.
    generate
        for (gi = 0; gi < `WORD_W; gi = gi + 1) begin : g_din_sync
            reg s1_r;
            reg s2_r;
            always @(posedge clk_sys) begin
                s1_r <= ext_data_in[gi];
                s2_r <= s1_r;
            end
            assign din_s2[gi] = s2_r;
        end
    endgenerate

    // ==========================================================
    // On-chip RAM decode: such accesses never reach the pins.
    always @* begin
        internal_hit = 1'h0;
        if (req_space == `SPACE_DATA) begin
            if (req_addr[`ADDR_MSB:`PAGE_LSB] == `B1_BASE_HI) begin
                internal_hit = 1'h1;
            end
            if (req_addr[`ADDR_MSB:`B2_OFS_BIT] == `B2_BASE_HI) begin
                internal_hit = 1'h1;
            end
            if (!block0_map_select && req_addr[`ADDR_MSB:`PAGE_LSB] == `B0_BASE_HI) begin
                internal_hit = 1'h1;
            end
            if (single_access_ram_in_data && req_addr[`ADDR_MSB:`SINGLE_ACCESS_RAM_LSB] == `SINGLE_ACCESS_RAM_HI) begin
                internal_hit = 1'h1;
            end
        end else if (req_space == `SPACE_PROG) begin
            if (block0_map_select && req_addr[`ADDR_MSB:`PAGE_LSB] == `B0_PROG_HI) begin
                internal_hit = 1'h1;
            end
            if (single_access_ram_in_prog && req_addr[`ADDR_MSB:`SINGLE_ACCESS_RAM_LSB] == `SINGLE_ACCESS_RAM_HI) begin
                internal_hit = 1'h1;
            end
        end
    end

    // ==========================================================
    // Request take and completion.
    always @* begin
        take = (state_r == ST_IDLE) && req_valid && !req_ready;
        bus_take = take && !internal_hit;
        finish = (state_r == ST_WAIT) && (wait_cnt_r == `WAIT_ZERO) && rdy_s2_r;
    end

    // ==========================================================
    // Next state and wait count.
    // The count adds the synchroniser delay, so ready and data are seen from this access.
    always @* begin
        state_nxt = state_r;
        wait_cnt_nxt = wait_cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (bus_take) begin
                    state_nxt = ST_WAIT;
                    wait_cnt_nxt = {1'h0, wait_states} + `SYNC_SETTLE;
                end
            end
            ST_WAIT: begin
                if (wait_cnt_r != `WAIT_ZERO) begin
                    wait_cnt_nxt = wait_cnt_r - `WAIT_ONE;
                end else if (rdy_s2_r) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Sequencer registers.
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            wait_cnt_r <= `WAIT_ZERO;
        end else begin
            state_r <= state_nxt;
            wait_cnt_r <= wait_cnt_nxt;
        end
    end

    // ==========================================================
    // Request handshake and response.
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            req_ready <= 1'h0;
            resp_valid <= 1'h0;
            resp_rdata <= `WORD_RESET;
            resp_internal <= 1'h0;
        end else begin
            req_ready <= take;
            resp_valid <= (take && internal_hit) || finish;
            if (take) begin
                resp_internal <= internal_hit;
            end
            if (take && internal_hit) begin
                resp_rdata <= `WORD_RESET;
            end else if (finish) begin
                resp_rdata <= din_s2;
            end
        end
    end

    // ==========================================================
    // Address and write data, held for the whole access.
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            ext_address_lines <= `WORD_RESET;
            ext_data_out <= `WORD_RESET;
        end else if (bus_take) begin
            ext_address_lines <= req_addr;
            ext_data_out <= req_wdata;
        end
    end

    // ==========================================================
    // Space selects, strobes and direction.
    always @(posedge clk_sys) begin
        if (!reset_n || finish) begin
            program_space_select_n <= 1'h1;
            data_space_select_n <= 1'h1;
            io_space_select_n <= 1'h1;
            global_select_n <= 1'h1;
            bus_cycle_strobe_n <= 1'h1;
            read_strobe_n <= 1'h1;
            write_strobe_n <= 1'h1;
            read_write <= 1'h1;
        end else if (bus_take) begin
            program_space_select_n <= ~(req_space == `SPACE_PROG);
            data_space_select_n <= ~(req_space == `SPACE_DATA);
            io_space_select_n <= ~(req_space == `SPACE_IO);
            global_select_n <= ~(req_space == `SPACE_GLOBAL);
            bus_cycle_strobe_n <= 1'h0;
            read_strobe_n <= req_write;
            write_strobe_n <= ~req_write;
            read_write <= ~req_write;
        end
    end

    // ==========================================================
    // Data bus drive: only while writing and not floated.
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            ext_data_oe_n <= 1'h1;
        end else if (bus_take) begin
            ext_data_oe_n <= ~(req_write && off_s2_r);
        end else if (finish) begin
            ext_data_oe_n <= 1'h1;
        end else if (state_r == ST_WAIT) begin
            ext_data_oe_n <= ~(~write_strobe_n && off_s2_r);
        end
    end

    // ==========================================================
    // Address and control drive follow the float input.
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            ext_address_oe_n <= 1'h1;
            control_oe_n <= 1'h1;
        end else begin
            ext_address_oe_n <= ~off_s2_r;
            control_oe_n <= ~off_s2_r;
        end
    end
endmodule

// *** rtl/ext_bus_defs.vh ***
// Constants for the external memory bus interface.
// How it works
// - Move 16-bit words over bidirectional data bus.
// - Release data lines unless writing, and always during reset.
// - Global tristate low floats address, data, controls.
// - Present 16-bit word address every external access.
// - Program select low only for program accesses.
// - Data select low only for data accesses.
// - I/O select low only for I/O accesses.
// - Ready low extends access one cycle, resample.
// - Direction line high except during writes.
// - Programmable zero to seven wait states.
// - Separate 64K program, data, I/O and global spaces.
// - Block zero maps to data or program space.
// - Blocks one and two are data only.
// - Single-access RAM maps program, data, or both.
// - Bus strobe low only during external cycles.
// - Drive data from write strobe falling edge.
// - Read strobe asserted on every external read.
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH
`define SPACE_PROG 2'h0
`define SPACE_DATA 2'h1
`define SPACE_IO 2'h2
`define SPACE_GLOBAL 2'h3
`define GLOBAL_TOP_BIT 15
`define B0_BASE_HI 8'h02
`define B0_PROG_HI 8'hFF
`define B1_BASE_HI 8'h03
`define B2_BASE_HI 11'h000
`define B2_LO_FIRST 5'h00
`define B2_OFS_BIT 5
`define SINGLE_ACCESS_RAM_HI 4'h8
`define WAIT_ZERO 4'h0
`define WAIT_ONE 4'h1
`define SYNC_SETTLE 4'h2
`define WORD_W 16
`define WORD_RESET 16'h0000
`define ADDR_MSB 15
`define PAGE_LSB 8
`define SINGLE_ACCESS_RAM_LSB 12
`endif

// *** dv/ext_bus_properties.sv ***
// Port checks for the external memory bus interface.
module ext_bus_properties (
    input wire clk_sys, reset_n, global_tristate_n, read_write, write_strobe_n,
    input wire [1:0] req_space,
    input wire [2:0] wait_states,
    input wire [15:0] ext_address_lines,
    input wire program_space_select_n, data_space_select_n, io_space_select_n,
    input wire bus_cycle_strobe_n, ext_data_oe_n, ext_address_oe_n, control_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_prog_select: assert property ($fell(program_space_select_n) |-> req_space == 2'h0)
        else $error("program select on wrong space");
    a_data_select: assert property ($fell(data_space_select_n) |-> req_space == 2'h1)
        else $error("data select on wrong space");
    a_io_select: assert property ($fell(io_space_select_n) |-> req_space == 2'h2)
        else $error("io select on wrong space");
    a_dir_write: assert property (!read_write |-> !write_strobe_n && !bus_cycle_strobe_n)
        else $error("direction low outside write");
    a_write_drive: assert property ($fell(write_strobe_n) |-> !ext_data_oe_n)
        else $error("data not driven at write strobe");
    a_access_stable: assert property (!bus_cycle_strobe_n && !$past(bus_cycle_strobe_n)
        |-> $stable(ext_address_lines) && $stable(read_write)
        && $stable(program_space_select_n) && $stable(data_space_select_n)
        && $stable(io_space_select_n)) else $error("access moved");
    a_wait_len: assert property ($fell(bus_cycle_strobe_n) && wait_states == 3'h7
        |-> !bus_cycle_strobe_n [*8]) else $error("wait states cut short");
    a_float_pins: assert property (!global_tristate_n [*4]
        |-> control_oe_n && ext_address_oe_n && ext_data_oe_n) else $error("pins not floated");
endmodule
bind external_memory_bus_interface ext_bus_properties chk (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .global_tristate_n(global_tristate_n),
    .read_write(read_write),
    .write_strobe_n(write_strobe_n),
    .req_space(req_space),
    .wait_states(wait_states),
    .ext_address_lines(ext_address_lines),
    .program_space_select_n(program_space_select_n),
    .data_space_select_n(data_space_select_n),
    .io_space_select_n(io_space_select_n),
    .bus_cycle_strobe_n(bus_cycle_strobe_n),
    .ext_data_oe_n(ext_data_oe_n),
    .ext_address_oe_n(ext_address_oe_n),
    .control_oe_n(control_oe_n)
);

// *** dv/ext_mem_model.sv ***
// External memory with a ready source on the far side of the bus.
module ext_mem_model (
    input wire logic clk_sys, data_space_select_n, io_space_select_n, global_select_n,
    input wire logic bus_cycle_strobe_n, read_strobe_n, write_strobe_n, ext_data_oe_n,
    input wire logic [15:0] ext_address_lines, ext_data_out,
    input wire logic [3:0] stall,
    output logic [15:0] ext_data_in,
    output logic ready_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:63];
    logic [15:0] last = 16'h0;
    logic [3:0] cnt = 4'h0;
    wire [1:0] sp = !data_space_select_n ? 2'h1 : !io_space_select_n ? 2'h2
        : !global_select_n ? 2'h3 : 2'h0;
    wire [5:0] idx = {sp, ext_address_lines[3:0]};
    assign ext_data_in = read_strobe_n ? ~last : mem[idx];
    assign ready_in = cnt == 4'h0;
    always @(posedge clk_sys) begin
        if (!write_strobe_n && !ext_data_oe_n) mem[idx] <= ext_data_out;
        if (!read_strobe_n) last <= mem[idx];
        cnt <= bus_cycle_strobe_n ? stall : cnt - {3'h0, cnt != 4'h0};
    end
endmodule

// *** dv/external_memory_bus_interface_tb.sv ***
// Self-checking bench for the external memory bus interface.
module external_memory_bus_interface_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, reset_n = 0, req_valid = 0, req_write = 0, block0_map_select = 0;
    logic single_access_ram_in_prog = 0, single_access_ram_in_data = 0, global_tristate_n = 1, ready_in;
    logic [1:0] req_space = 0;
    logic [2:0] wait_states = 0;
    logic [3:0] stall = 0;
    logic [15:0] req_addr = 0, req_wdata = 0, ext_data_in, ext_address_lines, ext_data_out, resp_rdata;
    logic req_ready, resp_valid, resp_internal, ext_address_oe_n, ext_data_oe_n, read_write;
    logic program_space_select_n, data_space_select_n, io_space_select_n, global_select_n;
    logic bus_cycle_strobe_n, read_strobe_n, write_strobe_n, control_oe_n;
    int n_fail = 0, checked = 0, cyc = 0, lat;
    external_memory_bus_interface uut (.*);
    ext_mem_model mem (.*);
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (++cyc > 3000) begin
        n_fail++;
        end_of_test;
    end
    task chk(string nm, logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task xfer(logic w, logic [1:0] s, logic [15:0] a, d);
        @(negedge clk_sys);
        {req_valid, req_write, req_space, req_addr, req_wdata} = {1'h1, w, s, a, d};
        lat = 0;
        do begin
            @(negedge clk_sys);
            lat++;
            if (req_ready === 1'h1) req_valid = 1'h0;
        end while (resp_valid !== 1'h1 && lat < 60);
        chk("resp_valid", 16'h1, {15'h0, resp_valid});
    endtask
    task t_spaces;
        for (int s = 0; s < 4; s++) xfer(1'h1, s[1:0], 16'h4003, 16'hA500 + 16'(s));
        for (int s = 0; s < 4; s++) begin
            xfer(1'h0, s[1:0], 16'h4003, 16'h0);
            chk("read_data", 16'hA500 + 16'(s), resp_rdata);
        end
    endtask
    task t_wait(logic [2:0] w, logic [3:0] st, int n);
        {wait_states, stall} = {w, st};
        xfer(1'h0, 2'h1, 16'h4003, 16'h0);
        chk("latency", 16'h1, {15'h0, lat >= n});
        chk("wait_data", 16'hA501, resp_rdata);
        {wait_states, stall} = 0;
    endtask
    task t_map(logic m, p, d, logic [1:0] s, logic [15:0] a, logic e);
        {block0_map_select, single_access_ram_in_prog, single_access_ram_in_data} = {m, p, d};
        xfer(1'h0, s, a, 16'h0);
        chk("internal", {15'h0, e}, {15'h0, resp_internal});
    endtask
    task t_float;
        global_tristate_n = 1'h0;
        repeat (6) @(negedge clk_sys);
        chk("float", 16'h7, {13'h0, control_oe_n, ext_address_oe_n, ext_data_oe_n});
        global_tristate_n = 1'h1;
        repeat (6) @(negedge clk_sys);
        chk("drive", 16'h1, {13'h0, control_oe_n, ext_address_oe_n, ext_data_oe_n});
    endtask
    task end_of_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        chk("reset", 16'h3F, {10'h0, program_space_select_n, data_space_select_n,
            io_space_select_n, bus_cycle_strobe_n, read_write, ext_data_oe_n});
        reset_n = 1'h1;
        repeat (3) @(negedge clk_sys);
        t_spaces;
        t_wait(3'h7, 4'h0, 10);
        t_wait(3'h0, 4'hC, 14);
        t_map(1'h0, 1'h0, 1'h0, 2'h1, 16'h0200, 1'h1);
        t_map(1'h1, 1'h0, 1'h0, 2'h1, 16'h0200, 1'h0);
        t_map(1'h1, 1'h0, 1'h0, 2'h0, 16'hFF00, 1'h1);
        t_map(1'h0, 1'h0, 1'h0, 2'h0, 16'h0300, 1'h0);
        t_map(1'h0, 1'h0, 1'h0, 2'h1, 16'h0300, 1'h1);
        t_map(1'h0, 1'h0, 1'h0, 2'h1, 16'h0010, 1'h1);
        t_map(1'h0, 1'h1, 1'h0, 2'h0, 16'h8000, 1'h1);
        t_map(1'h0, 1'h1, 1'h0, 2'h1, 16'h8000, 1'h0);
        t_map(1'h0, 1'h1, 1'h1, 2'h1, 16'h8000, 1'h1);
        t_float;
        end_of_test;
    end
endmodule
